// [src/apm_mode_cfg.sv]
/*
  Autopilot mode selection, configuration code storage, rate command,
  attitude hold and minimum impulse jet commanding.
  Assumes synchronous inputs on clk_sys_i and a single-cycle strobe register port.
*/
// Summary of operation
// - Mode comes from keyed commands and switch position; each mode needs its position.
// - Load key starts load routine showing code; edit key lets operator key new code. Code does not start the load routine while burn_sel_i is high.
// - Five-digit code A-E held and shown; A selects lander alone or docked. Code stores and range-checks A but no logic uses it.
// - B picks X translation: system A pair, system B pair, or four jets.
// - C sets hand-controller scale, 0.125 or 0.625 deg/s per bit.
// - D sets attitude deadband, 0.3 or 5.0 degrees.
// - E sets maneuver rate, 0.2, 0.5, 2 or 10 deg/s.
// - Automatic mode steers to guidance-written desired angles and issues engine commands.
// - One key enters minimum impulse, another returns to rate command; switch on each.
// - Reset defaults to rate command; selection held until opposite key.
// - One impulse per controller excursion past limit switches; detent return rearms.
// - No more than about five impulses per second.
// - Minimum impulse mode does no rate damping nor attitude hold.
// - Rate command key copies gimbal angles to desired angles, control starts.
// - Commanded maneuver rate limited to 20 deg/s on every axis.
// - Out of detent, controller deflection is a rate the vehicle is driven to.
// - Jets stop when rate error under 0.4 (descent) or 1.0 (ascent) deg/s.
// - Four jets above 1.4 (descent) or 2.0 (ascent) deg/s rate error.
// - In detent, rates are nulled, then angles captured and attitude held.
// - Large pitch and roll errors together use diagonal jets.
// - A failed X thruster makes selection use the remaining unfailed pair.
`timescale 1ns/100ps
`default_nettype none

module apm_mode_cfg
    import apm_pkg::*;
#(
    parameter int unsigned IMP_GAP_CYC = APM_IMP_GAP_CYC,
    parameter int unsigned IMP_WID_CYC = APM_IMP_WID_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire apm_bus_s bus_i,
    output logic [31:0] rdata_o,
    input wire logic [1:0] mode_sw_i,
    input wire logic guid_pri_i,
    input wire logic burn_sel_i,
    input wire logic ascent_i,
    input wire apm_hc_s hc_i,
    input wire logic [1:0] x_trans_i,
    input wire logic [2:0][15:0] veh_rate_i,
    input wire logic [2:0][15:0] gimbal_i,
    output logic [15:0] jet_o,
    output logic throttle_up_o,
    output logic throttle_dn_o,
    output logic engine_on_o,
    output logic [3:0] gimbal_drv_o,
    output apm_mode_e mode_o,
    output logic cfg_flash_o
);
    // Refuse counts the 25-bit timers or the pulse spacing cannot serve
    if (IMP_WID_CYC < 1 || IMP_GAP_CYC <= IMP_WID_CYC || IMP_GAP_CYC > 32'h01FFFFFF) begin : g_chk
        $error("apm_mode_cfg: impulse width or spacing out of range");
    end

    logic wr_cmd;
    logic wr_cfg;
    logic [7:0] key;
    logic cfg_ok;
    logic cfg_apply;
    apm_ld_e ld;
    apm_cfg_s cfg_q;
    apm_cfg_s cfg_in;
    logic cfg_err;
    logic minimp_sel;
    logic rcmd_entry;
    logic held;
    logic cap;
    logic [2:0][15:0] des;
    logic [15:0] xfail;
    logic [6:0] eng_q;
    apm_mode_e next_mode;
    logic signed [15:0] scale;
    logic signed [15:0] adb;
    logic signed [15:0] mrate;
    logic signed [15:0] rdb;
    logic signed [15:0] r4;
    logic [2:0] fpos;
    logic [2:0] fneg;
    logic [2:0] ffour;
    logic [2:0] slow;
    logic [15:0] x_sel;
    logic [15:0] next_jet;
    logic armed;
    logic imp_go;
    logic [24:0] gap;
    logic [24:0] imp_cnt;
    logic [15:0] imp_mask;
    logic [15:0] next_imp_mask;

    // Register port decode
    assign key = bus_i.wdata[7:0];
    assign wr_cmd = bus_i.wr && bus_i.addr == APM_REG_CMD;
    assign wr_cfg = bus_i.wr && bus_i.addr == APM_REG_CFG;
    assign cfg_in = bus_i.wdata[19:0];
    assign rcmd_entry = wr_cmd && key == APM_KEY_RCMD;

    // A code is complete only when every digit is in its range
    assign cfg_ok = cfg_in.a <= APM_BIT_MAX && cfg_in.b <= APM_B_MAX && cfg_in.c <= APM_BIT_MAX
                    && cfg_in.d <= APM_BIT_MAX && cfg_in.e <= APM_E_MAX;
    assign cfg_apply = wr_cfg && ld == APM_LD_EDIT && cfg_ok;

    // Load routine: show code, then accept a replacement
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ld <= APM_LD_IDLE;
        end else begin
            case (ld)
                APM_LD_IDLE: begin
                    if (wr_cmd && key == APM_KEY_LOAD && !burn_sel_i) begin
                        ld <= APM_LD_SHOW;
                    end
                end
                APM_LD_SHOW: begin
                    if (wr_cmd && key == APM_KEY_EDIT) begin
                        ld <= APM_LD_EDIT;
                    end else if (wr_cmd && key == APM_KEY_EXIT) begin
                        ld <= APM_LD_IDLE;
                    end
                end
                APM_LD_EDIT: begin
                    if (cfg_apply || (wr_cmd && key == APM_KEY_EXIT)) begin
                        ld <= APM_LD_IDLE;
                    end
                end
                default: ld <= APM_LD_IDLE;
            endcase
        end
    end

    // Configuration code, replaced only by a complete valid entry
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_q <= APM_CFG_RESET;
        end else if (cfg_apply) begin
            cfg_q <= cfg_in;
        end
    end

    // Sticky flag for a rejected code, cleared by the next load key
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_err <= 1'b0;
        end else if (wr_cfg && ld == APM_LD_EDIT && !cfg_ok) begin
            cfg_err <= 1'b1;
        end else if (wr_cmd && key == APM_KEY_LOAD) begin
            cfg_err <= 1'b0;
        end
    end

    // Flashing display while the code is shown or edited
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_flash_o <= 1'b0;
        end else begin
            cfg_flash_o <= ld != APM_LD_IDLE;
        end
    end

    // Keyed choice between minimum impulse and rate command
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            minimp_sel <= 1'b0;
        end else if (wr_cmd && key == APM_KEY_MINIMP) begin
            minimp_sel <= 1'b1;
        end else if (rcmd_entry) begin
            minimp_sel <= 1'b0;
        end
    end

    // Mode from switch position, guidance source and keyed choice
    always_comb begin
        if (!guid_pri_i || mode_sw_i == APM_SW_OFF) begin
            next_mode = APM_MODE_OFF;
        end else if (mode_sw_i == APM_SW_AUTO) begin
            next_mode = APM_MODE_AUTO;
        end else if (mode_sw_i == APM_SW_HOLD) begin
            next_mode = minimp_sel ? APM_MODE_MINIMP : APM_MODE_RATE;
        end else begin
            next_mode = APM_MODE_OFF;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_o <= APM_MODE_OFF;
        end else begin
            mode_o <= next_mode;
        end
    end

    // Field decode into working limits
    assign scale = cfg_q.c == 4'h0 ? APM_SCALE_FINE : APM_SCALE_NORM;
    assign adb = cfg_q.d == 4'h0 ? APM_ADB_NARROW : APM_ADB_WIDE;
    assign mrate = APM_MRATE[cfg_q.e[1:0]];
    assign rdb = ascent_i ? APM_RDB_ASC : APM_RDB_DES;
    assign r4 = ascent_i ? APM_R4_ASC : APM_R4_DES;

    // Per-axis rate loop: 0 pitch, 1 roll, 2 yaw
    for (genvar a = 0; a < 3; a++) begin : g_axis
        logic signed [15:0] hcr;
        logic signed [15:0] aerr;
        logic signed [15:0] cmd;
        logic signed [15:0] err;
        logic signed [15:0] vr;
        logic on;
        assign vr = $signed(veh_rate_i[a]);
        assign hcr = 16'($signed(hc_i.rate[a])) * scale;
        assign aerr = $signed(des[a]) - $signed(gimbal_i[a]);
        // Commanded rate: stick rate, steering rate, or zero to null
        always_comb begin
            if (mode_o == APM_MODE_RATE && hc_i.detent) begin
                if (hcr > APM_RATE_MAX) begin
                    cmd = APM_RATE_MAX;
                end else if (hcr < -APM_RATE_MAX) begin
                    cmd = -APM_RATE_MAX;
                end else begin
                    cmd = hcr;
                end
            end else if (mode_o == APM_MODE_AUTO || (mode_o == APM_MODE_RATE && held)) begin
                if (aerr > adb) begin
                    cmd = mrate;
                end else if (aerr < -adb) begin
                    cmd = -mrate;
                end else begin
                    cmd = '0;
                end
            end else begin
                cmd = '0;
            end
        end
        assign err = cmd - vr;
        assign on = mode_o == APM_MODE_AUTO || mode_o == APM_MODE_RATE;
        assign fpos[a] = on && err > rdb;
        assign fneg[a] = on && err < -rdb;
        assign ffour[a] = on && (err > r4 || err < -r4);
        assign slow[a] = vr < rdb && vr > -rdb;
    end

    // X translation pair with failed-jet fallback
    function automatic logic [15:0] xpick(input logic [15:0] pa, input logic [15:0] pb,
                                          input logic [15:0] fail, input logic [3:0] b);
        logic [15:0] want;
        want = b == 4'h0 ? pa : (b == 4'h1 ? pb : pa | pb);
        if ((want & fail) == 16'h0000) begin
            return want;
        end else if ((pa & fail) == 16'h0000) begin
            return pa;
        end else if ((pb & fail) == 16'h0000) begin
            return pb;
        end else begin
            return 16'h0000;
        end
    endfunction

    always_comb begin
        if (mode_o == APM_MODE_OFF) begin
            x_sel = 16'h0000;
        end else if (x_trans_i[0]) begin
            x_sel = xpick(APM_XP_A, APM_XP_B, xfail, cfg_q.b);
        end else if (x_trans_i[1]) begin
            x_sel = xpick(APM_XN_A, APM_XN_B, xfail, cfg_q.b);
        end else begin
            x_sel = 16'h0000;
        end
    end

    // Attitude capture once rates are nulled in detent
    assign cap = mode_o == APM_MODE_RATE && !hc_i.detent && !held && (&slow);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            held <= 1'b0;
        end else if (rcmd_entry || cap) begin
            held <= 1'b1;
        end else if (hc_i.detent || mode_o != APM_MODE_RATE) begin
            held <= 1'b0;
        end
    end

    // Desired angles: guidance writes, capture copies gimbal angles
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            des <= '0;
        end else begin
            for (int a = 0; a < 3; a++) begin
                if (rcmd_entry || cap) begin
                    des[a] <= gimbal_i[a];
                end else if (bus_i.wr && bus_i.addr == APM_REG_DES0 + 8'(4 * a)) begin
                    des[a] <= bus_i.wdata[15:0];
                end
            end
        end
    end

    // Failed-jet marks and guidance engine commands
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            xfail <= 16'h0000;
            eng_q <= 7'h00;
        end else begin
            if (bus_i.wr && bus_i.addr == APM_REG_XFAIL) begin
                xfail <= bus_i.wdata[15:0];
            end
            if (bus_i.wr && bus_i.addr == APM_REG_ENG) begin
                eng_q <= bus_i.wdata[6:0];
            end
        end
    end

    // Engine commands pass only in automatic mode
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            throttle_up_o <= 1'b0;
            throttle_dn_o <= 1'b0;
            engine_on_o <= 1'b0;
            gimbal_drv_o <= 4'h0;
        end else begin
            throttle_up_o <= mode_o == APM_MODE_AUTO && eng_q[0];
            throttle_dn_o <= mode_o == APM_MODE_AUTO && eng_q[1] && !eng_q[0];
            engine_on_o <= mode_o == APM_MODE_AUTO && eng_q[2];
            gimbal_drv_o <= mode_o == APM_MODE_AUTO ? eng_q[6:3] : 4'h0;
        end
    end

    // Impulse on a limit excursion, armed by a return to detent
    assign imp_go = mode_o == APM_MODE_MINIMP && armed && (|hc_i.limit) && gap == '0;

    always_comb begin
        next_imp_mask = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            if (hc_i.limit[i]) begin
                next_imp_mask = next_imp_mask | APM_ROT2[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            armed <= 1'b1;
        end else if (imp_go) begin
            armed <= 1'b0;
        end else if (!hc_i.detent) begin
            armed <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            gap <= '0;
            imp_cnt <= '0;
            imp_mask <= 16'h0000;
        end else if (imp_go) begin
            gap <= 25'(IMP_GAP_CYC - 1);
            imp_cnt <= 25'(IMP_WID_CYC);
            imp_mask <= next_imp_mask;
        end else begin
            if (gap != '0) begin
                gap <= gap - 25'h1;
            end
            if (imp_cnt != '0) begin
                imp_cnt <= imp_cnt - 25'h1;
            end
        end
    end

    // Jet mix: impulses or rotation, with translation added in either case
    always_comb begin
        next_jet = 16'h0000;
        if (mode_o == APM_MODE_MINIMP) begin
            if (imp_cnt != '0) begin
                next_jet = imp_mask;
            end
        end else if (ffour[0] && ffour[1]) begin
            next_jet = APM_DIAG[{fneg[0], fneg[1]}];
        end else begin
            for (int a = 0; a < 2; a++) begin
                if (fpos[a] || fneg[a]) begin
                    next_jet = next_jet | APM_ROT2[a * 2 + int'(fneg[a])];
                end
                if (ffour[a]) begin
                    next_jet = next_jet | APM_ROT4[a * 2 + int'(fneg[a])];
                end
            end
        end
        if (mode_o != APM_MODE_MINIMP && (fpos[2] || fneg[2])) begin
            next_jet = next_jet | APM_ROT2[4 + int'(fneg[2])];
            if (ffour[2]) begin
                next_jet = next_jet | APM_ROT4[4 + int'(fneg[2])];
            end
        end
        next_jet = next_jet | x_sel;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            jet_o <= 16'h0000;
        end else begin
            jet_o <= next_jet;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= 32'h00000000;
            if (bus_i.rd) begin
                case (bus_i.addr)
                    APM_REG_CFG: rdata_o <= {12'h000, cfg_q};
                    APM_REG_STAT: rdata_o <= {24'h000000, cfg_err, held, armed,
                                              ld == APM_LD_EDIT, ld == APM_LD_SHOW,
                                              minimp_sel, mode_o};
                    APM_REG_DES0: rdata_o <= {16'h0000, des[0]};
                    APM_REG_DES0 + 8'h04: rdata_o <= {16'h0000, des[1]};
                    APM_REG_DES0 + 8'h08: rdata_o <= {16'h0000, des[2]};
                    APM_REG_XFAIL: rdata_o <= {16'h0000, xfail};
                    APM_REG_ENG: rdata_o <= {25'h0000000, eng_q};
                    default: rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    property p_off_quiet;
        @(posedge clk_sys_i) disable iff (rst_i) mode_o == APM_MODE_OFF |=> jet_o == 16'h0000;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("jets fired in off mode");

    property p_reset_rate;
        @(posedge clk_sys_i) $past(rst_i) && !rst_i |-> !minimp_sel;
    endproperty
    a_reset_rate: assert property (p_reset_rate) else $error("reset did not select rate");

    property p_cfg_hold;
        @(posedge clk_sys_i) disable iff (rst_i) !cfg_apply |=> cfg_q == $past(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("code changed without entry");

    property p_cfg_edit;
        @(posedge clk_sys_i) disable iff (rst_i)
            wr_cfg && ld != APM_LD_EDIT |=> cfg_q == $past(cfg_q);
    endproperty
    a_cfg_edit: assert property (p_cfg_edit) else $error("code taken outside edit");

    property p_rcmd_copy;
        @(posedge clk_sys_i) disable iff (rst_i)
            rcmd_entry |=> des == $past(gimbal_i) && held && !minimp_sel;
    endproperty
    a_rcmd_copy: assert property (p_rcmd_copy) else $error("angles not copied on rate key");

    property p_one_impulse;
        @(posedge clk_sys_i) disable iff (rst_i) imp_go |=> !imp_go [*8];
    endproperty
    a_one_impulse: assert property (p_one_impulse) else $error("second impulse too soon");

    property p_gap;
        @(posedge clk_sys_i) disable iff (rst_i) imp_go |=> gap == 25'(IMP_GAP_CYC - 1) && !armed;
    endproperty
    a_gap: assert property (p_gap) else $error("impulse spacing not started");

    property p_minimp_only;
        @(posedge clk_sys_i) disable iff (rst_i)
            mode_o == APM_MODE_MINIMP && imp_cnt == '0 && x_sel == 16'h0000 |=> jet_o == 16'h0000;
    endproperty
    a_minimp_only: assert property (p_minimp_only) else $error("damping in impulse mode");

    property p_xfail;
        @(posedge clk_sys_i) disable iff (rst_i)
            (x_sel & xfail) == 16'h0000 || ((APM_XP_A | APM_XN_A) & xfail) != 16'h0000
            && ((APM_XP_B | APM_XN_B) & xfail) != 16'h0000;
    endproperty
    a_xfail: assert property (p_xfail) else $error("failed X thruster selected");
endmodule // apm_mode_cfg

`default_nettype wire

// [common/apm_pkg.sv]
/*
  Constants, types and register map of the autopilot mode and configuration block.
  Assumes a 100 MHz system clock; rates in units of 0.025 deg/s, angles in 0.01 deg.
*/
package apm_pkg;
    localparam int APM_CLK_MHZ = 100;
    // Register byte offsets
    localparam logic [7:0] APM_REG_CMD = 8'h00;
    localparam logic [7:0] APM_REG_CFG = 8'h04;
    localparam logic [7:0] APM_REG_STAT = 8'h08;
    localparam logic [7:0] APM_REG_DES0 = 8'h0C;
    localparam logic [7:0] APM_REG_XFAIL = 8'h18;
    localparam logic [7:0] APM_REG_ENG = 8'h1C;
    // Keyed command codes (decimal 48, 21, 34, 76, 77)
    localparam logic [7:0] APM_KEY_LOAD = 8'h30;
    localparam logic [7:0] APM_KEY_EDIT = 8'h15;
    localparam logic [7:0] APM_KEY_EXIT = 8'h22;
    localparam logic [7:0] APM_KEY_MINIMP = 8'h4C;
    localparam logic [7:0] APM_KEY_RCMD = 8'h4D;
    // Mode switch positions
    localparam logic [1:0] APM_SW_OFF = 2'h0;
    localparam logic [1:0] APM_SW_AUTO = 2'h1;
    localparam logic [1:0] APM_SW_HOLD = 2'h2;
    typedef enum logic [1:0] {APM_MODE_OFF, APM_MODE_AUTO, APM_MODE_RATE, APM_MODE_MINIMP} apm_mode_e;
    typedef enum logic [1:0] {APM_LD_IDLE, APM_LD_SHOW, APM_LD_EDIT} apm_ld_e;
    // Configuration code, one digit per nibble
    typedef struct packed {
        logic [3:0] a;
        logic [3:0] b;
        logic [3:0] c;
        logic [3:0] d;
        logic [3:0] e;
    } apm_cfg_s;
    localparam apm_cfg_s APM_CFG_RESET = 20'h00101;
    localparam logic [3:0] APM_B_MAX = 4'h2;
    localparam logic [3:0] APM_BIT_MAX = 4'h1;
    localparam logic [3:0] APM_E_MAX = 4'h3;
    // Register bus request and hand controller carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } apm_bus_s;
    typedef struct packed {
        logic detent;
        logic [5:0] limit;
        logic [2:0][7:0] rate;
    } apm_hc_s;
    // Rates (0.025 deg/s per count)
    localparam logic signed [15:0] APM_SCALE_FINE = 16'h0005;
    localparam logic signed [15:0] APM_SCALE_NORM = 16'h0019;
    localparam logic signed [15:0] APM_RATE_MAX = 16'h0320;
    localparam logic signed [15:0] APM_RDB_DES = 16'h0010;
    localparam logic signed [15:0] APM_RDB_ASC = 16'h0028;
    localparam logic signed [15:0] APM_R4_DES = 16'h0038;
    localparam logic signed [15:0] APM_R4_ASC = 16'h0050;
    localparam logic signed [15:0] APM_MRATE [4] = '{16'h0008, 16'h0014, 16'h0050, 16'h0190};
    // Attitude deadbands (0.01 deg per count)
    localparam logic signed [15:0] APM_ADB_NARROW = 16'h001E;
    localparam logic signed [15:0] APM_ADB_WIDE = 16'h01F4;
    // Impulse timing
    localparam int APM_IMP_GAP_MS = 200;
    localparam int APM_IMP_GAP_CYC = APM_IMP_GAP_MS * APM_CLK_MHZ * 1000;
    localparam int APM_IMP_WID_US = 14;
    localparam int APM_IMP_WID_CYC = APM_IMP_WID_US * APM_CLK_MHZ;
    // Jet masks, jet n on bit n-1; index axis*2+negative
    localparam logic [15:0] APM_ROT2 [6] = '{16'h0808, 16'h0404, 16'h0090, 16'h0060,
                                             16'h1010, 16'h2020};
    localparam logic [15:0] APM_ROT4 [6] = '{16'h8080, 16'h4040, 16'h0900, 16'h0600,
                                             16'h0101, 16'h0202};
    localparam logic [15:0] APM_DIAG [4] = '{16'h8008, 16'h4004, 16'h0880, 16'h0440};
    localparam logic [15:0] APM_XP_A = 16'h0202;
    localparam logic [15:0] APM_XP_B = 16'h2020;
    localparam logic [15:0] APM_XN_A = 16'h1010;
    localparam logic [15:0] APM_XN_B = 16'h0101;
endpackage

// [verif/apm_crew.sv]
/* Hand controller and jet driver model.
   Assumes jets are sampled on the rising system clock. */
`timescale 1ns/100ps
`default_nettype none
module apm_crew
    import apm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic [5:0] defl_i,
    input wire logic [15:0] jet_i,
    output var apm_hc_s hc_o,
    output var logic [7:0] pulses_o = 8'h00,
    output var logic [15:0] last_o = 16'h0000
);
    logic prev = 1'b0;
    // Detent discrete up whenever the stick is pushed
    assign hc_o = '{detent: |defl_i, limit: defl_i, rate: '0};
    // Count firings, keep last pattern
    always_ff @(posedge clk_sys_i) begin
        prev <= |jet_i;
        if (|jet_i && !prev) pulses_o <= pulses_o + 8'h01;
        if (|jet_i) last_o <= jet_i;
    end
endmodule // apm_crew
`default_nettype wire

// [verif/apm_mode_cfg_bench.sv]
/* Bench for apm_mode_cfg: modes, code load, keys, impulses.
   Assumes apm_crew as stick and jet driver. */
`timescale 1ns/100ps
`default_nettype none
module apm_mode_cfg_bench;
    import apm_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic gp = 1'b1;
    apm_bus_s bus = '0;
    logic [31:0] rdata_o, rv;
    logic [1:0] sw = APM_SW_HOLD;
    logic [5:0] defl = '0;
    logic [1:0] xt = '0;
    wire logic [6:0] eng;
    logic [2:0][15:0] vr = '0;
    logic [15:0] jet_o, last;
    apm_mode_e mode_o;
    logic flash;
    apm_hc_s hc;
    logic [7:0] pulses, p0;
    int failures = 0;
    int compares = 0;
    // Rows: guidance bit, switch, expected mode
    logic [4:0] rows [6] = '{5'h10, 5'h15, 5'h1A, 5'h1C, 5'h08, 5'h1A};
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    apm_mode_cfg #(.IMP_GAP_CYC(40), .IMP_WID_CYC(4)) dut (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata_o), .mode_sw_i(sw), .guid_pri_i(gp),
        .burn_sel_i(1'b0), .ascent_i(1'b0), .hc_i(hc), .x_trans_i(xt), .veh_rate_i(vr),
        .gimbal_i({3{16'h0123}}), .jet_o(jet_o), .throttle_up_o(eng[0]),
        .throttle_dn_o(eng[1]), .engine_on_o(eng[2]), .gimbal_drv_o(eng[6:3]),
        .mode_o(mode_o), .cfg_flash_o(flash));
    apm_crew crew (.clk_sys_i(clk_sys_i), .defl_i(defl), .jet_i(jet_o), .hc_o(hc),
        .pulses_o(pulses), .last_o(last));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task complete_run;
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        failures++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wait_n(2);
        chk("mode", 32'h2, {30'h0, mode_o});
        rd(APM_REG_CFG);
        chk("cfg reset", 32'(APM_CFG_RESET), rv);
        // Engine commands stored now, passed only while automatic
        wr(APM_REG_ENG, 32'h7D);
        foreach (rows[i]) begin
            @(posedge clk_sys_i);
            gp <= rows[i][4];
            sw <= rows[i][3:2];
            wait_n(3);
            chk("mode", {30'h0, rows[i][1:0]}, {30'h0, mode_o});
            chk("engine", rows[i][1:0] == 2'h1 ? 32'h7D : 32'h0, {25'h0, eng});
        end
        $display("Test modes done");
        wr(APM_REG_CMD, 32'(APM_KEY_LOAD));
        wait_n(2);
        chk("flash", 32'h1, {31'h0, flash});
        wr(APM_REG_CFG, 32'h12113);
        wr(APM_REG_CMD, 32'(APM_KEY_EDIT));
        wr(APM_REG_CFG, 32'h13113);
        rd(APM_REG_CFG);
        chk("cfg kept", 32'h00101, rv);
        wr(APM_REG_CFG, 32'h12113);
        wr(APM_REG_CMD, 32'(APM_KEY_EXIT));
        rd(APM_REG_CFG);
        chk("cfg new", 32'h12113, rv);
        chk("flash", 32'h0, {31'h0, flash});
        $display("Test load done");
        wr(APM_REG_CMD, 32'(APM_KEY_RCMD));
        rd(APM_REG_DES0);
        chk("desired", 32'h0123, rv);
        vr <= {3{16'h0100}};
        wr(APM_REG_CMD, 32'(APM_KEY_MINIMP));
        wait_n(24);
        chk("mode", 32'h3, {30'h0, mode_o});
        p0 = pulses;
        // Second push lands inside the spacing time, third after it
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys_i);
            defl <= (k == 2) ? 6'h02 : 6'h01;
            wait_n(12);
            chk("jets", 32'(APM_ROT2[k / 2]), {16'h0, last});
            @(posedge clk_sys_i);
            defl <= 6'h00;
            wait_n(k == 1 ? 50 : 2);
            chk("pulses", {24'h0, p0 + 8'(k / 2 + 1)}, {24'h0, pulses});
        end
        $display("Test impulses done");
        // X translation: four jets by code, then the clean pair when one jet fails
        @(posedge clk_sys_i);
        xt <= 2'h1;
        wait_n(3);
        chk("x jets", 32'(APM_XP_A | APM_XP_B), {16'h0, jet_o});
        wr(APM_REG_XFAIL, 32'h2);
        wait_n(3);
        chk("x fallback", 32'(APM_XP_B), {16'h0, jet_o});
        $display("Test x jets done");
        // Mid-run reset from minimum impulse comes back in rate command
        @(posedge clk_sys_i);
        xt <= 2'h0;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wait_n(2);
        chk("mode", 32'h2, {30'h0, mode_o});
        rd(APM_REG_CFG);
        chk("cfg reset", 32'(APM_CFG_RESET), rv);
        $display("Test reset done");
        complete_run();
    end
endmodule // apm_mode_cfg_bench
`default_nettype wire
